// File: e1lf_pkg.sv
// shared constants and types of the e1 line framing and configuration block
// assumes a single 250 MHz clock domain; switch pins read 1 when a switch is on
package e1lf_pkg;
  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_CRCERR = 4'h8;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_FREQ_KHZ = 250000;
  localparam int LINE_RATE_KHZ = 2048;
  localparam int INT_DIV = CLK_FREQ_KHZ / LINE_RATE_KHZ;
  // ---------------------------------------------------------------
  // frame structure
  // ---------------------------------------------------------------
  localparam logic [4:0] FRAMING_SLOT = 5'h00;
  localparam logic [4:0] SIGNALLING_SLOT = 5'h10;
  localparam logic [4:0] LAST_SLOT = 5'h1f;
  localparam logic [3:0] LAST_FRAME = 4'hf;
  localparam logic [2:0] LAST_SMF_FRAME = 3'h7;
  localparam logic [4:0] RATE_CLEAR_CHANNEL = 5'h1f;
  localparam logic [3:0] MF_ALIGN_WORD = 4'h0;
  localparam logic [2:0] MF_ALIGN_LAST = 3'h3;
  localparam logic [1:0] CAS_LOSS_MISSES = 2'h2;
  localparam logic [7:0] IDLE_BYTE = 8'hff;
  localparam logic [3:0] CRC_POLY = 4'h3;
  // ---------------------------------------------------------------
  // synchroniser bit positions
  // ---------------------------------------------------------------
  localparam int SY_DTE_DATA = 0;
  localparam int SY_DTE_CLK = 1;
  localparam int SY_RX_NEG = 2;
  localparam int SY_RX_POS = 3;
  localparam int SY_RX_CLK = 4;
  localparam int SY_LINE_CODE = 5;
  localparam int SY_CLK_LOW = 6;
  localparam int SY_CLK_HIGH = 7;
  localparam int SY_RATE = 8;
  localparam int SY_CAS = 13;
  localparam int SY_CRC = 14;
  localparam int SY_OPT = 15;
  localparam int SY_ADDR = 20;
  localparam int SYNC_W = 28;
  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    CLK_NETWORK = 2'h0,
    CLK_INTERNAL = 2'h1,
    CLK_EXTERNAL = 2'h2
  } e1lf_clk_t;
  typedef enum logic [1:0] {SYM_ZERO = 2'h0, SYM_MARK = 2'h1, SYM_BIP = 2'h2, SYM_VIOL = 2'h3} e1lf_sym_t;
  typedef enum logic [1:0] {CS_SYNC0 = 2'h0, CS_SYNC1 = 2'h1, CS_STRAP = 2'h3, CS_RUN = 2'h2} e1lf_cs_t;
  // options: [0] csu remote loop, [1] loop response off, [2] dte test off,
  // [3] front panel off, [4] terminal management instead of network management
  typedef struct packed {
    logic [4:0] options;
    logic crcEn;
    logic casEn;
    logic [4:0] rateCode;
    e1lf_clk_t clockSel;
    logic amiMode;
    logic softwareControl;
  } e1lf_cfg_t;
  localparam e1lf_cfg_t CFG_RESET = '{options: 5'h06, crcEn: 1'b0, casEn: 1'b0,
    rateCode: RATE_CLEAR_CHANNEL, clockSel: CLK_INTERNAL, amiMode: 1'b0, softwareControl: 1'b0};
endpackage : e1lf_pkg

// File: e1lf_line_encoder.sv
// bipolar line encoder, hdb3 or ami
// assumes one bitStrobe per line bit from the framer on the same clock
`timescale 1ns/1ps
`default_nettype none
module e1lf_line_encoder
  import e1lf_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // bit stream
  input wire logic bitIn,
  input wire logic bitStrobe,
  input wire logic amiMode,
  // line pulses
  output logic linePos,
  output logic lineNeg
);
  typedef struct packed {
    e1lf_sym_t [3:0] sym;
    logic lastPol;
    logic oddMarks;
    logic pos;
    logic neg;
  } e1lf_enc_t;
  e1lf_enc_t q, d;
  e1lf_sym_t newSym;
  e1lf_sym_t midSym;
  // next state: four-symbol lookahead, output from the oldest entry
  always_comb begin
    d = q;
    newSym = bitIn ? SYM_MARK : SYM_ZERO;
    midSym = q.sym[2];
    if (bitStrobe) begin
      if (!amiMode && !bitIn && q.sym[2:0] == '0) begin
        newSym = SYM_VIOL;
        if (!q.oddMarks) begin
          midSym = SYM_BIP;
        end
        d.oddMarks = 1'b0;
      end else if (bitIn) begin
        d.oddMarks = ~q.oddMarks;
      end
      unique case (q.sym[3])
        SYM_ZERO: begin
          d.pos = 1'b0;
          d.neg = 1'b0;
        end
        SYM_MARK, SYM_BIP: begin
          d.lastPol = ~q.lastPol;
          d.pos = ~q.lastPol;
          d.neg = q.lastPol;
        end
        SYM_VIOL: begin
          d.pos = q.lastPol;
          d.neg = ~q.lastPol;
        end
      endcase
      d.sym[3] = midSym;
      d.sym[2] = q.sym[1];
      d.sym[1] = q.sym[0];
      d.sym[0] = newSym;
    end
  end
  // state register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
  assign linePos = q.pos;
  assign lineNeg = q.neg;
endmodule : e1lf_line_encoder
`default_nettype wire

// File: e1lf_line_decoder.sv
// bipolar line decoder, hdb3 or ami
// assumes rxStrobe marks one sampled line bit on the same clock
`timescale 1ns/1ps
`default_nettype none
module e1lf_line_decoder
  import e1lf_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // sampled line
  input wire logic rxPos,
  input wire logic rxNeg,
  input wire logic rxStrobe,
  input wire logic amiMode,
  // decoded bits
  output logic bitOut,
  output logic bitValid
);
  typedef struct packed {
    logic [3:0] data;
    logic lastPol;
    logic seenPulse;
    logic out;
    logic valid;
  } e1lf_dec_t;
  e1lf_dec_t q, d;
  logic pulse;
  logic isViol;
  // next state: four-bit delay so a substituted pulse can be erased
  always_comb begin
    d = q;
    pulse = rxPos | rxNeg;
    isViol = !amiMode && pulse && q.seenPulse && (rxPos == q.lastPol);
    d.valid = rxStrobe;
    if (rxStrobe) begin
      d.out = q.data[3];
      d.data = {q.data[2] & ~isViol, q.data[1:0], pulse & ~isViol};
      if (pulse) begin
        d.lastPol = rxPos;
        d.seenPulse = 1'b1;
      end
    end
  end
  // state register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
  assign bitOut = q.out;
  assign bitValid = q.valid;
endmodule : e1lf_line_decoder
`default_nettype wire

// File: e1lf_line_framing_config.sv
// e1 line framing and configuration: switch decode, timing select, framer,
// multiframe check, checksum multiframe and line coding
// assumes switch and line pins asynchronous to clk; register port on clk
//
// The implementer's own choices: strobed register access and the address map.
`timescale 1ns/1ps
`default_nettype none
module e1lf_line_framing_config
  import e1lf_pkg::*;
#(
  parameter logic [7:0] FRAME_WORD = 8'hff
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire logic [3:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWrStrobe,
  input wire logic regRdStrobe,
  output logic [31:0] regRdData,
  // configuration switches, 1 = on
  input wire logic lineCodeSwitch,
  input wire logic clockSelectHigh,
  input wire logic clockSelectLow,
  input wire logic [4:0] rateCodeSwitches,
  input wire logic signallingMultiframeEnable,
  input wire logic checksumMultiframeEnable,
  input wire logic [4:0] optionSwitches,
  input wire logic [7:0] cardAddressSwitches,
  // network line
  input wire logic rxLineClk,
  input wire logic rxLinePos,
  input wire logic rxLineNeg,
  output logic txLinePos,
  output logic txLineNeg,
  // dte serial port
  input wire logic dteTermClk,
  input wire logic dteTxData,
  output logic dteTxTake,
  output logic dteRxData,
  output logic dteRxValid,
  // status
  output logic casLoss,
  output logic framedMode,
  output logic [4:0] optionsActive
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [SYNC_W-1:0] sync1;
    logic [SYNC_W-1:0] sync2;
    logic rxClkLast;
    logic dteClkLast;
    e1lf_cs_t cfgState;
    logic resetMode;
    e1lf_cfg_t ctrl;
    e1lf_cfg_t eff;
    logic framed;
    logic [6:0] divCount;
    logic [2:0] txBitIdx;
    logic [4:0] txSlot;
    logic [3:0] txFrame;
    logic [4:0] txUsed;
    logic txBit;
    logic txStrobe;
    logic txTake;
    logic rxStrobe;
    logic rxPos;
    logic rxNeg;
    logic [2:0] rxBitIdx;
    logic [4:0] rxSlot;
    logic [3:0] rxFrame;
    logic [4:0] rxUsed;
    logic rxData;
    logic rxValid;
    logic [2:0] casWord;
    logic [1:0] casMisses;
    logic casLoss;
    logic [3:0] txCrc;
    logic [3:0] txCrcHold;
    logic [3:0] rxCrc;
    logic [3:0] rxCrcHold;
    logic [3:0] rxCbits;
    logic crcErr;
    logic [15:0] crcErrCount;
    logic [31:0] rdData;
  } e1lf_top_t;
  e1lf_top_t q, d;
  e1lf_cfg_t dip;
  logic rxEdge, dteEdge, intTick, txTick, txData, rxData, crcActive;
  logic decBit, decValid, casCheck, casHit, rxIsC, txIsC;
  logic [SYNC_W-1:0] pins;

  assign pins = {cardAddressSwitches, optionSwitches, checksumMultiframeEnable,
    signallingMultiframeEnable, rateCodeSwitches, clockSelectHigh, clockSelectLow,
    lineCodeSwitch, rxLineClk, rxLinePos, rxLineNeg, dteTermClk, dteTxData};

  // in framed mode timeslot 16 goes to data only without signalling multiframe
  function automatic logic isDataSlot(input logic [4:0] slot, input logic [4:0] used,
                                      input e1lf_cfg_t c);
    if (c.rateCode == RATE_CLEAR_CHANNEL) begin
      return 1'b1;
    end
    if (slot == FRAMING_SLOT) begin
      return 1'b0;
    end
    if (c.casEn && slot == SIGNALLING_SLOT) begin
      return 1'b0;
    end
    return used <= c.rateCode;
  endfunction : isDataSlot

  // checksum shift, x^4 + x + 1
  function automatic logic [3:0] crcStep(input logic [3:0] crc, input logic b);
    return {crc[2:0], 1'b0} ^ ((b ^ crc[3]) ? CRC_POLY : 4'h0);
  endfunction : crcStep

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    d = q;
    // synchronisers and edge detect
    d.sync1 = pins;
    d.sync2 = q.sync1;
    d.rxClkLast = q.sync2[SY_RX_CLK];
    d.dteClkLast = q.sync2[SY_DTE_CLK];
    rxEdge = q.sync2[SY_RX_CLK] & ~q.rxClkLast;
    dteEdge = q.sync2[SY_DTE_CLK] & ~q.dteClkLast;
    // software control register
    if (regWrStrobe && regAddr == REG_CTRL) begin
      d.ctrl = e1lf_cfg_t'(regWrData[15:0]);
    end
    // power-up strap capture after the synchronisers settle
    unique case (q.cfgState)
      CS_SYNC0: d.cfgState = CS_SYNC1;
      CS_SYNC1: d.cfgState = CS_STRAP;
      CS_STRAP: begin
        // all address switches on forces switch control
        if (&q.sync2[SY_ADDR +: 8]) begin
          d.resetMode = 1'b1;
          d.ctrl.softwareControl = 1'b0;
        end
        d.cfgState = CS_RUN;
      end
      CS_RUN: d.cfgState = CS_RUN;
    endcase
    dip.amiMode = q.sync2[SY_LINE_CODE];
    unique case ({q.sync2[SY_CLK_HIGH], q.sync2[SY_CLK_LOW]})
      2'b10: dip.clockSel = CLK_INTERNAL;
      2'b01: dip.clockSel = CLK_EXTERNAL;
      default: dip.clockSel = CLK_NETWORK;
    endcase
    dip.rateCode = ~q.sync2[SY_RATE +: 5];
    dip.casEn = q.sync2[SY_CAS];
    dip.crcEn = q.sync2[SY_CRC];
    dip.options = q.sync2[SY_OPT +: 5];
    dip.softwareControl = 1'b0;
    // switches unless software control is on
    d.eff = q.ctrl.softwareControl ? q.ctrl : dip;
    d.framed = d.eff.rateCode != RATE_CLEAR_CHANNEL;
    crcActive = q.framed && q.eff.crcEn;
    // transmit timing source
    intTick = q.divCount == 7'(INT_DIV - 1);
    d.divCount = intTick ? 7'h00 : q.divCount + 7'h01;
    unique case (q.eff.clockSel)
      CLK_NETWORK: txTick = rxEdge;
      CLK_INTERNAL: txTick = intTick;
      CLK_EXTERNAL: txTick = dteEdge;
      default: txTick = 1'b0;
    endcase
    // transmit framer
    d.txStrobe = txTick;
    d.txTake = 1'b0;
    txIsC = q.txSlot == FRAMING_SLOT && q.txBitIdx == 3'h0 && !q.txFrame[0];
    txData = isDataSlot(q.txSlot, q.txUsed, q.eff);
    if (txTick) begin
      if (txData) begin
        // unframed carries data in every slot
        d.txBit = q.sync2[SY_DTE_DATA];
        d.txTake = 1'b1;
      end else if (q.txSlot == FRAMING_SLOT) begin
        // checksum bits and remote error indication
        if (crcActive && q.txBitIdx == 3'h0) begin
          d.txBit = q.txFrame[0] ? ~q.crcErr : q.txCrcHold[~q.txFrame[2:1]];
        end else begin
          d.txBit = q.txFrame[0] ? IDLE_BYTE[~q.txBitIdx] : FRAME_WORD[~q.txBitIdx];
        end
      end else if (q.txSlot == SIGNALLING_SLOT && q.txFrame == 4'h0
                   && q.txBitIdx <= MF_ALIGN_LAST) begin
        // alignment word in the upper bits
        d.txBit = MF_ALIGN_WORD[~q.txBitIdx[1:0]];
      end else begin
        d.txBit = IDLE_BYTE[~q.txBitIdx];
      end
      d.txCrc = crcStep(q.txCrc, (crcActive && txIsC) ? 1'b0 : d.txBit);
      d.txBitIdx = q.txBitIdx + 3'h1;
      if (&q.txBitIdx) begin
        d.txSlot = q.txSlot + 5'h01;
        d.txUsed = q.txUsed + {4'h0, txData && q.framed};
        if (q.txSlot == LAST_SLOT) begin
          d.txFrame = q.txFrame + 4'h1;
          d.txUsed = 5'h00;
          if (q.txFrame[2:0] == LAST_SMF_FRAME) begin
            d.txCrcHold = d.txCrc;
            d.txCrc = 4'h0;
          end
        end
      end
    end
    // receive side
    d.rxStrobe = rxEdge;
    d.rxPos = q.sync2[SY_RX_POS];
    d.rxNeg = q.sync2[SY_RX_NEG];
    d.rxValid = 1'b0;
    rxIsC = q.rxSlot == FRAMING_SLOT && q.rxBitIdx == 3'h0 && !q.rxFrame[0];
    rxData = isDataSlot(q.rxSlot, q.rxUsed, q.eff);
    casCheck = 1'b0;
    casHit = {q.casWord, decBit} == MF_ALIGN_WORD;
    if (decValid) begin
      d.rxValid = rxData;
      d.rxData = decBit;
      if (q.rxSlot == SIGNALLING_SLOT && q.rxFrame == 4'h0 && q.rxBitIdx <= MF_ALIGN_LAST) begin
        d.casWord = {q.casWord[1:0], decBit};
        casCheck = q.rxBitIdx == MF_ALIGN_LAST && q.framed && q.eff.casEn;
      end
      if (rxIsC) begin
        d.rxCbits = {q.rxCbits[2:0], decBit};
      end
      d.rxCrc = crcStep(q.rxCrc, (crcActive && rxIsC) ? 1'b0 : decBit);
      d.rxBitIdx = q.rxBitIdx + 3'h1;
      if (&q.rxBitIdx) begin
        d.rxSlot = q.rxSlot + 5'h01;
        d.rxUsed = q.rxUsed + {4'h0, rxData && q.framed};
        if (q.rxSlot == LAST_SLOT) begin
          d.rxFrame = q.rxFrame + 4'h1;
          d.rxUsed = 5'h00;
          if (q.rxFrame[2:0] == LAST_SMF_FRAME) begin
            // compare received checksum with local one
            d.crcErr = crcActive && d.rxCbits != q.rxCrcHold;
            if (d.crcErr) begin
              d.crcErrCount = q.crcErrCount + 16'h0001;
            end
            d.rxCrcHold = d.rxCrc;
            d.rxCrc = 4'h0;
          end
        end
      end
    end
    // two misses set, one hit clears
    if (!(q.framed && q.eff.casEn)) begin
      d.casMisses = 2'h0;
      d.casLoss = 1'b0;
    end else if (casCheck) begin
      if (casHit) begin
        d.casMisses = 2'h0;
        d.casLoss = 1'b0;
      end else begin
        if (q.casMisses != CAS_LOSS_MISSES) begin
          d.casMisses = q.casMisses + 2'h1;
        end
        if (q.casMisses + 2'h1 >= CAS_LOSS_MISSES) begin
          d.casLoss = 1'b1;
        end
      end
    end
    // register read data, valid in the following cycle only
    d.rdData = 32'h0000_0000;
    if (regRdStrobe) begin
      unique case (regAddr)
        REG_CTRL: d.rdData = {16'h0000, q.ctrl};
        REG_STATUS: d.rdData = {13'h0, q.sync2[SY_ADDR +: 8], q.eff.rateCode,
                                q.eff.clockSel, q.eff.amiMode, q.resetMode, q.framed,
                                q.casLoss};
        REG_CRCERR: d.rdData = {16'h0000, q.crcErrCount};
        default: d.rdData = 32'h0000_0000;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= '0;
      q.ctrl <= CFG_RESET;
      q.eff <= CFG_RESET;
      q.cfgState <= CS_SYNC0;
    end else begin
      q <= d;
    end
  end

  // line coders
  e1lf_line_encoder u_enc (
    .clk(clk),
    .rst(rst),
    .bitIn(q.txBit),
    .bitStrobe(q.txStrobe),
    .amiMode(q.eff.amiMode),
    .linePos(txLinePos),
    .lineNeg(txLineNeg)
  );
  e1lf_line_decoder u_dec (
    .clk(clk),
    .rst(rst),
    .rxPos(q.rxPos),
    .rxNeg(q.rxNeg),
    .rxStrobe(q.rxStrobe),
    .amiMode(q.eff.amiMode),
    .bitOut(decBit),
    .bitValid(decValid)
  );

  // outputs
  assign regRdData = q.rdData;
  assign dteTxTake = q.txTake;
  assign dteRxData = q.rxData;
  assign dteRxValid = q.rxValid;
  assign casLoss = q.casLoss;
  assign framedMode = q.framed;
  assign optionsActive = q.eff.options;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  sequence s_strapAllOn;
    q.cfgState == CS_STRAP && (&q.sync2[SY_ADDR +: 8]);
  endsequence
  sequence s_secondMiss;
    casCheck && !casHit && q.casMisses == 2'h1;
  endsequence
  a_line_code_dip: assert property (@(posedge clk) disable iff (rst)
    !q.ctrl.softwareControl |=> q.eff.amiMode == $past(q.sync2[SY_LINE_CODE]))
    else $error("line code does not follow switch");
  a_clock_mode_decode: assert property (@(posedge clk) disable iff (rst)
    (!q.ctrl.softwareControl && q.sync2[SY_CLK_HIGH] == q.sync2[SY_CLK_LOW])
    |=> q.eff.clockSel == CLK_NETWORK)
    else $error("equal clock switches not network mode");
  a_rate_code_inverted: assert property (@(posedge clk) disable iff (rst)
    !q.ctrl.softwareControl |=> q.eff.rateCode == ~$past(q.sync2[SY_RATE +: 5]))
    else $error("rate code not inverted switches");
  a_unframed_all_data: assert property (@(posedge clk) disable iff (rst)
    (txTick && !q.framed) |=> dteTxTake)
    else $error("unframed bit not taken from dte");
  a_framing_slot_free: assert property (@(posedge clk) disable iff (rst)
    (txTick && q.framed && q.txSlot == FRAMING_SLOT) |=> !dteTxTake)
    else $error("user data in framing slot");
  a_align_word_zero: assert property (@(posedge clk) disable iff (rst)
    (txTick && q.framed && q.eff.casEn && q.txSlot == SIGNALLING_SLOT && q.txFrame == 4'h0
     && q.txBitIdx <= MF_ALIGN_LAST) |=> !q.txBit && !dteTxTake)
    else $error("alignment word bit not zero");
  a_cas_loss_set: assert property (@(posedge clk) disable iff (rst)
    s_secondMiss |=> casLoss [*2])
    else $error("second miss did not declare loss");
  a_cas_loss_clear: assert property (@(posedge clk) disable iff (rst)
    (casCheck && casHit) |=> !casLoss)
    else $error("good alignment did not clear loss");
  a_unframed_no_crc: assert property (@(posedge clk) disable iff (rst)
    !q.framed && !$past(q.framed) |=> $stable(q.crcErrCount))
    else $error("checksum counted while unframed");
  a_strap_forces_dip: assert property (@(posedge clk) disable iff (rst)
    s_strapAllOn |=> q.resetMode && !q.ctrl.softwareControl ##1 q.eff.rateCode == dip.rateCode)
    else $error("strap did not force switch control");
endmodule : e1lf_line_framing_config
`default_nettype wire

// File: e1lf_remote_unit.sv
// remote unit model: drives marks on the receive line with its own clock
// assumes the block samples the line on the rising receive clock
`timescale 1ns/1ps
`default_nettype none
module e1lf_remote_unit (
  // receive line toward the block
  output logic rxLineClk,
  output logic rxLinePos,
  output logic rxLineNeg
);
  // free-running line clock, data moved on its falling edge
  initial begin
    rxLineClk = 1'b0;
    rxLinePos = 1'b1;
    rxLineNeg = 1'b0;
    forever begin
      #244.1 rxLineClk = ~rxLineClk;
      if (!rxLineClk) {rxLinePos, rxLineNeg} = {rxLineNeg, rxLinePos};
    end
  end
endmodule : e1lf_remote_unit
`default_nettype wire

// File: e1lf_line_framing_config_tb.sv
// self-checking bench of the e1 line framing block
// assumes the remote unit model drives the receive line
`timescale 1ns/1ps
`default_nettype none
module e1lf_line_framing_config_tb
  import e1lf_pkg::*;
;
  logic clk, rst, wr, rd, lc, csh, csl, cas, crc, dTerm, dData;
  logic rxClk, rxP, rxN, tP, tN, rD, rV, loss, framed, take;
  logic [3:0] addr;
  logic [31:0] wd, rdd, st;
  logic [4:0] rate, opt, optAct;
  logic [7:0] card;
  int fails, checks;
  e1lf_line_framing_config u_dut (.clk(clk), .rst(rst), .regAddr(addr), .regWrData(wd),
    .regWrStrobe(wr), .regRdStrobe(rd), .regRdData(rdd), .lineCodeSwitch(lc),
    .clockSelectHigh(csh), .clockSelectLow(csl), .rateCodeSwitches(rate),
    .signallingMultiframeEnable(cas), .checksumMultiframeEnable(crc), .optionSwitches(opt),
    .cardAddressSwitches(card), .rxLineClk(rxClk), .rxLinePos(rxP), .rxLineNeg(rxN),
    .txLinePos(tP), .txLineNeg(tN), .dteTermClk(dTerm), .dteTxData(dData), .dteTxTake(take),
    .dteRxData(rD), .dteRxValid(rV), .casLoss(loss), .framedMode(framed),
    .optionsActive(optAct));
  e1lf_remote_unit u_remote (.rxLineClk(rxClk), .rxLinePos(rxP), .rxLineNeg(rxN));
  // 250 MHz clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic chk(string n, logic [31:0] e, logic [31:0] s);
    checks++;
    if (s !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic wrReg(logic [3:0] a, logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wd <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wrReg
  // settle switch changes, then one read
  task automatic rdReg(logic [3:0] a);
    repeat (8) @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 st = rdd;
    @(posedge clk);
  endtask : rdReg
  task automatic testDefaults();
    rdReg(REG_STATUS);
    chk("status", 32'h7d0, st & 32'h7ff);
    chk("options", 32'h6, optAct);
    rdReg(REG_CTRL);
    chk("control", 32'h31f4, st);
    rdReg(4'hc);
    chk("unmapped", 32'h0, st);
  endtask : testDefaults
  task automatic testSwitches();
    logic [4:0] codes[4] = '{5'h00, 5'h01, 5'h1e, 5'h1f};
    e1lf_clk_t exp[4] = '{CLK_NETWORK, CLK_EXTERNAL, CLK_INTERNAL, CLK_NETWORK};
    for (int i = 0; i < 4; i++) begin
      rate <= ~codes[i];
      {csh, csl} <= i[1:0];
      opt <= codes[i];
      rdReg(REG_STATUS);
      chk("rate", codes[i], st[10:6]);
      chk("framed", codes[i] != 5'h1f, framed);
      chk("clock select", exp[i], st[5:4]);
      chk("option switches", codes[i], optAct);
    end
    csh <= 1'b1;
    csl <= 1'b0;
    opt <= 5'h06;
  endtask : testSwitches
  task automatic testSoftware();
    wrReg(REG_CTRL, 32'h325b);
    rdReg(REG_STATUS);
    chk("software status", 32'h16a, st & 32'h7fa);
    wrReg(REG_CTRL, 32'h31f4);
  endtask : testSoftware
  // unframed run at the internal rate, pulses and received marks counted
  task automatic lineRun(logic ami, logic b);
    int n[2] = '{0, 0};
    int nSame = 0, nV = 0, nZ = 0, pol = 2;
    logic pP, pN;
    lc <= ami;
    dData <= b;
    repeat (600) @(posedge clk);
    repeat (2500) begin
      pP = tP;
      pN = tN;
      @(posedge clk);
      #1;
      if (tP && !pP || tN && !pN) begin
        nSame += (pol == tP);
        pol = tP;
        n[tP]++;
      end
      nV += rV;
      nZ += rV && !rD;
    end
    chk("pulses", b || !ami, n[0] > 0 && n[1] > 0);
    chk("violations", !b && !ami, nSame > 0);
    chk("rx ones", 1, nV > 0 && nZ == 0);
    chk("cas loss", 0, loss);
  endtask : lineRun
  // dte terminal clock times the transmitter: one take per rising edge
  task automatic testExternal();
    int takes = 0;
    {csh, csl} <= 2'b01;
    repeat (8) @(posedge clk);
    repeat (32) begin
      @(posedge clk);
      dTerm <= ~dTerm;
      repeat (20) begin
        @(negedge clk);
        takes += take;
      end
    end
    @(posedge clk);
    {csh, csl} <= 2'b10;
    chk("dte takes", 16, takes);
  endtask : testExternal
  // all address switches on through a reset force switch control
  task automatic testStrap();
    @(posedge clk);
    card <= 8'hff;
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    wrReg(REG_CTRL, 32'h31f5);
    rdReg(REG_CTRL);
    chk("strap control", 32'h31f4, st);
    rdReg(REG_STATUS);
    chk("strap status", 32'h1ff, {st[18:11], st[2]});
  endtask : testStrap
  task automatic report_and_stop();
    $display("Checks %0d mismatches %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : report_and_stop
  // reset, then the scenarios
  initial begin
    rst = 1'b1;
    {wr, rd, lc, csl, cas, crc, dTerm, dData, fails, checks} = '0;
    csh = 1'b1;
    {addr, wd, rate, card} = '0;
    opt = 5'h06;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    testDefaults();
    testSwitches();
    testSoftware();
    testExternal();
    lineRun(1'b1, 1'b1);
    lineRun(1'b1, 1'b0);
    lineRun(1'b0, 1'b0);
    lineRun(1'b0, 1'b1);
    testStrap();
    report_and_stop();
  end
endmodule : e1lf_line_framing_config_tb
`default_nettype wire
